//--- sync_out_gen.sv
// Frame and multiframe sync output generator with APB configuration
//
// Functional notes
// RULE_01: frame sync output drives actively only while its enable is set.
// RULE_02: multiframe sync output drives actively only while its enable is set.
// RULE_03: a disabled sync output is held constantly low.
// RULE_04: frame sync clock mode is an 8 kHz square wave, 50% duty.
// RULE_05: frame sync pulse mode rests high, low for one clock-three period per 125 us.
// RULE_06: frame sync invert flips polarity in both clock and pulse mode.
// RULE_07: multiframe clock mode is a 2 kHz square wave, 50% duty.
// RULE_08: multiframe pulse mode pulses low one clock-three period every 500 us.
// RULE_09: multiframe invert flips polarity in both forms.
// RULE_10: software must run clock three from the main DPLL at 1.544 MHz or above.
// RULE_11: seven synthesizers accept custom frequencies within the 2 kHz and 8 kHz grids.
// RULE_12: software must use the analog multiplier PLL above 77.76 MHz.
// RULE_13: each output may carry the custom frequency or an integer submultiple; the code only stores and reads back the divider.
// RULE_14: pulse mode with invert rests low with a one-period high pulse.
`timescale 1ns/100ps
`default_nettype none

module sync_out_gen #(
    parameter int FRAME_CYCLES = sync_out_pkg::FRAME_CYCLES_DEF
) (
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire sync_out_pkg::apb_req_t apb_req,
    output var  logic [31:0]            prdata,
    output var  logic                   pready,
    output var  logic                   pslverr,
    input  wire logic                   output_clock_three,
    output var  logic                   frame_sync_out,
    output var  logic                   multiframe_sync_out
);

    localparam logic [15:0] FRAME_LAST = 16'(FRAME_CYCLES - 1);
    localparam logic [15:0] FRAME_HALF = 16'(FRAME_CYCLES / 2);

    // Whole module state, registered in one place
    typedef struct packed {
        logic [2:0]                                     oc3_sync;
        logic                                           oc3_lvl;
        logic                                           fs_en;
        logic                                           mf_en;
        logic                                           fast_pulse;
        logic                                           fast_inv;
        logic                                           slow_pulse;
        logic                                           slow_inv;
        sync_out_pkg::custom_t [sync_out_pkg::NUM_SYNTH-1:0] custom;
        logic [15:0]                                    fcnt;
        logic [1:0]                                     fidx;
        logic                                           fs_pend;
        logic                                           fs_act;
        logic                                           mf_pend;
        logic                                           mf_act;
        logic                                           fs_out;
        logic                                           mf_out;
        logic                                           pready;
        logic                                           pslverr;
        logic [31:0]                                    prdata;
    } state_t;

    state_t q;
    state_t d;

    logic                              oc3_agree;
    logic                              oc3_rise;
    logic                              frame_end;
    logic                              mf_end;
    logic                              apb_setup;
    logic                              wr_en;
    logic                              cust_hit;
    logic [2:0]                        cust_idx;
    logic [31:0]                       rd_word;
    logic                              rd_err;
    logic [sync_out_pkg::NUM_SYNTH-1:0] custom_ok;
    logic                              fs_wave;
    logic                              mf_wave;

    // Clock three edge: counted only once the second and third stages agree
    assign oc3_agree = q.oc3_sync[1] == q.oc3_sync[2];
    assign oc3_rise  = oc3_agree && q.oc3_sync[2] && !q.oc3_lvl;

    // Frame and multiframe boundaries from the core timebase
    assign frame_end = q.fcnt == FRAME_LAST;
    assign mf_end    = frame_end && (q.fidx == sync_out_pkg::MF_LAST_IDX);

    // APB decode; writes land only at the access edge that samples pready
    assign apb_setup = apb_req.psel && !apb_req.penable;
    assign wr_en     = apb_req.psel && apb_req.penable && apb_req.pwrite
                       && q.pready && !q.pslverr;
    assign cust_hit  = (apb_req.paddr >= sync_out_pkg::CUSTOM_BASE_OFS)
                       && (apb_req.paddr <= sync_out_pkg::CUSTOM_LAST_OFS)
                       && (apb_req.paddr[1:0] == 2'h0);
    assign cust_idx  = 3'((apb_req.paddr - sync_out_pkg::CUSTOM_BASE_OFS) >> 2);

    // Custom frequency legality per synthesizer, in kHz
    genvar gi;
    for (gi = 0; gi < sync_out_pkg::NUM_SYNTH; gi++)
    begin : g_valid
        assign custom_ok[gi] = (q.custom[gi].freq != '0)
            && (((q.custom[gi].freq[0] == 1'b0)
                 && (q.custom[gi].freq <= sync_out_pkg::SLOW_LIMIT_KHZ))
             || ((q.custom[gi].freq[2:0] == 3'h0)
                 && (q.custom[gi].freq <= sync_out_pkg::FAST_LIMIT_KHZ))); // RULE_11
    end

    // Waveforms before enable and inversion; pulse forms rest high
    assign fs_wave = q.fast_pulse ? !q.fs_act : (q.fcnt < FRAME_HALF);        // RULE_04
    assign mf_wave = q.slow_pulse ? !q.mf_act
                                  : (q.fidx < sync_out_pkg::MF_HALF_IDX);      // RULE_07

    // Read mux; unmapped addresses answer with pslverr
    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_err  = 1'b0;
        if (cust_hit)
        begin
            rd_word[sync_out_pkg::DIV_LSB +: sync_out_pkg::DIV_W] = q.custom[cust_idx].div;
            rd_word[sync_out_pkg::FREQ_LSB +: sync_out_pkg::FREQ_W] = q.custom[cust_idx].freq;
        end
        else
        begin
            case (apb_req.paddr)
                sync_out_pkg::OUT_CFG_OFS:
                begin
                    rd_word[sync_out_pkg::FS_EN_BIT] = q.fs_en;
                    rd_word[sync_out_pkg::MF_EN_BIT] = q.mf_en;
                end
                sync_out_pkg::SYNC_CFG_OFS:
                begin
                    rd_word[sync_out_pkg::FAST_PULSE_BIT] = q.fast_pulse;
                    rd_word[sync_out_pkg::FAST_INV_BIT]   = q.fast_inv;
                    rd_word[sync_out_pkg::SLOW_PULSE_BIT] = q.slow_pulse;
                    rd_word[sync_out_pkg::SLOW_INV_BIT]   = q.slow_inv;
                end
                sync_out_pkg::STATUS_OFS:
                begin
                    rd_word[sync_out_pkg::FS_LVL_BIT]  = q.fs_out;
                    rd_word[sync_out_pkg::MF_LVL_BIT]  = q.mf_out;
                    rd_word[sync_out_pkg::OC3_LVL_BIT] = q.oc3_lvl;
                    rd_word[sync_out_pkg::VALID_LSB +: sync_out_pkg::NUM_SYNTH] = custom_ok;
                end
                default:
                begin
                    rd_err = 1'b1;
                end
            endcase
        end
    end

    // Next state
    always_comb
    begin
        d = q;

        // Three-stage sampler for the foreign clock three
        d.oc3_sync = {q.oc3_sync[1:0], output_clock_three};
        if (oc3_agree)
        begin
            d.oc3_lvl = q.oc3_sync[2];
        end

        // Free-running 125 us frame counter and frame index in multiframe
        d.fcnt = frame_end ? 16'h0000 : 16'(q.fcnt + 16'h0001);
        if (frame_end)
        begin
            d.fidx = 2'(q.fidx + 2'h1);
        end

        // Pulse arms at the boundary and fires on the next clock-three rise;
        // a boundary in the same cycle as the rise re-arms, so no frame is lost
        d.fs_pend = frame_end || (q.fs_pend && !oc3_rise);                     // RULE_05
        d.mf_pend = mf_end || (q.mf_pend && !oc3_rise);                        // RULE_08
        if (oc3_rise)
        begin
            d.fs_act = q.fs_pend;                                              // RULE_05
            d.mf_act = q.mf_pend;                                              // RULE_08
        end

        // Disabled outputs sit low whatever the inversion setting
        d.fs_out = q.fs_en && (fs_wave ^ q.fast_inv); // RULE_01 RULE_03 RULE_14
        d.mf_out = q.mf_en && (mf_wave ^ q.slow_inv); // RULE_02 RULE_03 RULE_14

        // Zero-wait answer: pready high in the access cycle only
        d.pready  = apb_setup;
        d.pslverr = apb_setup && rd_err;
        d.prdata  = (apb_setup && !apb_req.pwrite) ? rd_word : 32'h0000_0000;

        // Register writes
        if (wr_en)
        begin
            if (cust_hit)
            begin
                // Divider for the submultiple is only stored and read back; zero is kept and read as is
                d.custom[cust_idx].div  =
                    apb_req.pwdata[sync_out_pkg::DIV_LSB +: sync_out_pkg::DIV_W];  // RULE_13
                d.custom[cust_idx].freq =
                    apb_req.pwdata[sync_out_pkg::FREQ_LSB +: sync_out_pkg::FREQ_W];
            end
            else if (apb_req.paddr == sync_out_pkg::OUT_CFG_OFS)
            begin
                d.fs_en = apb_req.pwdata[sync_out_pkg::FS_EN_BIT];
                d.mf_en = apb_req.pwdata[sync_out_pkg::MF_EN_BIT];
            end
            else if (apb_req.paddr == sync_out_pkg::SYNC_CFG_OFS)
            begin
                d.fast_pulse = apb_req.pwdata[sync_out_pkg::FAST_PULSE_BIT];
                d.fast_inv   = apb_req.pwdata[sync_out_pkg::FAST_INV_BIT];       // RULE_06
                d.slow_pulse = apb_req.pwdata[sync_out_pkg::SLOW_PULSE_BIT];
                d.slow_inv   = apb_req.pwdata[sync_out_pkg::SLOW_INV_BIT];       // RULE_09
            end
        end
    end

    // State register, synchronous reset
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            q        <= '0;
            q.custom <= {sync_out_pkg::NUM_SYNTH{sync_out_pkg::CUSTOM_RST}};
        end
        else
        begin
            q <= d;
        end
    end

    // Ports come straight from the state flops
    assign prdata              = q.prdata;
    assign pready              = q.pready;
    assign pslverr             = q.pslverr;
    assign frame_sync_out      = q.fs_out;
    assign multiframe_sync_out = q.mf_out;

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_fs_fire;
        q.fs_en && q.fast_pulse && !q.fast_inv && q.fs_pend && oc3_rise;
    endsequence

    sequence s_mf_fire;
        q.mf_en && q.slow_pulse && !q.slow_inv && q.mf_pend && oc3_rise;
    endsequence

    a_fs_off_low: assert property (!q.fs_en |=> !frame_sync_out) // RULE_01 RULE_03
        else $error("frame sync not low while disabled");

    a_mf_off_low: assert property (!q.mf_en |=> !multiframe_sync_out) // RULE_02 RULE_03
        else $error("multiframe sync not low while disabled");

    a_fs_clock_half: assert property (q.fs_en && !q.fast_pulse && q.fcnt == FRAME_HALF // RULE_04
        |=> frame_sync_out == $past(q.fast_inv))
        else $error("frame sync clock wrong in second half");

    a_fs_clock_start: assert property (q.fs_en && !q.fast_pulse && frame_end // RULE_06
        && $stable(q.fast_inv) ##1 q.fs_en && !q.fast_pulse
        |=> frame_sync_out == !$past(q.fast_inv))
        else $error("frame sync clock wrong at frame start");

    a_fs_pulse_fire: assert property (s_fs_fire |=> q.fs_act ##1 !frame_sync_out) // RULE_05
        else $error("frame sync pulse did not go low");

    a_fs_pulse_hold: assert property (q.fs_act && !oc3_rise |=> q.fs_act) // RULE_05
        else $error("frame sync pulse ended without clock three edge");

    a_fs_inv_rest: assert property (q.fs_en && q.fast_pulse && q.fast_inv // RULE_14
        && !q.fs_act |=> !frame_sync_out)
        else $error("inverted frame pulse not resting low");

    a_mf_clock_half: assert property (q.mf_en && !q.slow_pulse && frame_end // RULE_07
        && q.fidx == 2'h1 ##1 q.mf_en && !q.slow_pulse && $stable(q.slow_inv)
        |=> multiframe_sync_out == $past(q.slow_inv))
        else $error("multiframe clock wrong in second half");

    a_mf_pulse_fire: assert property (s_mf_fire |=> q.mf_act ##1 !multiframe_sync_out) // RULE_08
        else $error("multiframe pulse did not go low");

    a_mf_set_wins: assert property (mf_end |=> q.mf_pend) // RULE_08
        else $error("multiframe boundary lost");

    a_mf_inv_rest: assert property (q.mf_en && q.slow_pulse && q.slow_inv // RULE_09 RULE_14
        && !q.mf_act |=> !multiframe_sync_out)
        else $error("inverted multiframe rest wrong");

    a_custom_grid: assert property (custom_ok[0] |-> q.custom[0].freq[0] == 1'b0 // RULE_11
        && (q.custom[0].freq <= sync_out_pkg::SLOW_LIMIT_KHZ
            || q.custom[0].freq[2:0] == 3'h0))
        else $error("custom frequency accepted off grid");

    a_custom_div: assert property (wr_en && cust_hit && cust_idx == 3'h0 // RULE_13
        |=> q.custom[0].div == $past(apb_req.pwdata[31:24]))
        else $error("submultiple divider not stored");

    a_apb_answer: assert property (apb_setup |=> pready ##1 !pready)
        else $error("APB answer not in access cycle");

endmodule : sync_out_gen

`default_nettype wire

//--- sync_out_gen_tb.sv
// Self-checking testbench for the sync output generator
`timescale 1ns/100ps
`default_nettype none

module sync_out_gen_tb;
    localparam int FC  = 40; // Short frame keeps the run brief
    localparam int OC3 = 4;  // Clock three period in core cycles

    logic                   core_clk;
    logic                   rst_n;
    sync_out_pkg::apb_req_t apb_req;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   output_clock_three;
    logic                   frame_sync_out;
    logic                   multiframe_sync_out;
    logic [15:0]            fs_hi, fs_lo, mf_hi, mf_lo;
    logic [31:0]            rd;
    logic                   rerr;
    logic [6:0]             vmask;
    logic [18:0]            f;
    int                     err_count;
    int                     checked;
    // Settings above the slow limit presume routing through the analog multiplier PLL
    logic [18:0] freqs [7] = '{19'h0_0002, 19'h1_2fc0, 19'h1_2fc2, 19'h4_bf00,
                               19'h4_bf08, 19'h0_0003, 19'h0_0000};

    // Clock three runs at a quarter of the core clock rate, well above 1.544 MHz
    always #2.5 core_clk = ~core_clk;
    always #10 output_clock_three = ~output_clock_three;

    sync_out_gen #(.FRAME_CYCLES(FC)) u_dut (
        .core_clk           (core_clk),
        .rst_n              (rst_n),
        .apb_req            (apb_req),
        .prdata             (prdata),
        .pready             (pready),
        .pslverr            (pslverr),
        .output_clock_three (output_clock_three),
        .frame_sync_out     (frame_sync_out),
        .multiframe_sync_out(multiframe_sync_out)
    );
    sync_run_monitor u_fs_mon (.core_clk(core_clk), .rst_n(rst_n), .sync_in(frame_sync_out),
                               .high_run(fs_hi), .low_run(fs_lo));
    sync_run_monitor u_mf_mon (.core_clk(core_clk), .rst_n(rst_n), .sync_in(multiframe_sync_out),
                               .high_run(mf_hi), .low_run(mf_lo));

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check_word

    // Setup starts one edge after entry, so back-to-back calls never collide
    task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        int n;
        @(posedge core_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        // Only pready or the watchdog ends a wait; the wait length is compared afterwards
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1);
        rd   = prdata;
        rerr = pslverr;
        check_word(32'(n), 32'h0000_0001, "bus wait cycles");
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb_xfer

    // Let every monitor see several whole multiframes before comparing
    task automatic check_runs(input int fh, input int fl, input int mh, input int ml);
        repeat (32 * FC) @(posedge core_clk);
        check_word(32'(fs_hi), 32'(fh), "frame high run");
        check_word(32'(fs_lo), 32'(fl), "frame low run");
        check_word(32'(mf_hi), 32'(mh), "multiframe high run");
        check_word(32'(mf_lo), 32'(ml), "multiframe low run");
    endtask : check_runs

    // Outputs under mask must stay low; an unknown also shows as a mismatch
    task automatic check_quiet(input logic [1:0] mask);
        logic [1:0] seen;
        seen = 2'b00;
        repeat (16 * FC)
        begin
            @(posedge core_clk);
            seen = seen | ({multiframe_sync_out, frame_sync_out} & mask);
        end
        check_word(32'(seen), 32'h0000_0000, "disabled output level");
    endtask : check_quiet

    // Frame level where the multiframe line rises, to catch a wrong polarity
    task automatic check_phase(input logic inv);
        logic prev;
        prev = 1'b1;
        repeat (8 * FC)
        begin
            @(posedge core_clk);
            if (prev === 1'b0 && multiframe_sync_out === 1'b1)
                check_word(32'(frame_sync_out), 32'(!inv), "frame level at multiframe rise");
            prev = multiframe_sync_out;
        end
    endtask : check_phase

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    // Main sequence
    initial
    begin
        core_clk = 1'b0;
        output_clock_three = 1'b0;
        rst_n = 1'b0;
        apb_req = '0;
        err_count = 0;
        checked = 0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        apb_xfer(1'b0, sync_out_pkg::OUT_CFG_OFS, 32'h0000_0000);
        check_word(rd, 32'h0000_0000, "enables after reset");
        apb_xfer(1'b0, sync_out_pkg::CUSTOM_BASE_OFS, 32'h0000_0000);
        check_word(rd, 32'h0100_0000, "custom after reset");
        apb_xfer(1'b0, 8'h2c, 32'h0000_0000);
        check_word({rd[30:0], rerr}, 32'h0000_0001, "unmapped read");
        apb_xfer(1'b1, sync_out_pkg::SYNC_CFG_OFS, 32'h0000_000f);
        check_quiet(2'b11);
        apb_xfer(1'b1, sync_out_pkg::SYNC_CFG_OFS, 32'h0000_0000);
        apb_xfer(1'b1, sync_out_pkg::OUT_CFG_OFS, 32'h0000_0001);
        check_quiet(2'b10);
        check_runs(FC / 2, FC / 2, 0, 0);
        apb_xfer(1'b1, sync_out_pkg::OUT_CFG_OFS, 32'h0000_0002);
        check_quiet(2'b01);
        apb_xfer(1'b1, sync_out_pkg::OUT_CFG_OFS, 32'h0000_0003);
        // Bit 0 of m picks pulse form, bit 1 picks inversion, same for both outputs
        for (int m = 0; m < 4; m++)
        begin
            apb_xfer(1'b1, sync_out_pkg::SYNC_CFG_OFS,
                     (32'(m[0]) << sync_out_pkg::FAST_PULSE_BIT) |
                     (32'(m[1]) << sync_out_pkg::FAST_INV_BIT) |
                     (32'(m[0]) << sync_out_pkg::SLOW_PULSE_BIT) |
                     (32'(m[1]) << sync_out_pkg::SLOW_INV_BIT));
            if (!m[0])
                check_runs(FC / 2, FC / 2, 2 * FC, 2 * FC);
            else if (!m[1])
                check_runs(FC - OC3, OC3, 4 * FC - OC3, OC3);
            else
                check_runs(OC3, FC - OC3, OC3, 4 * FC - OC3);
            if (!m[0])
                check_phase(m[1]);
        end
        // Custom settings carry the divider for the submultiple as well
        for (int i = 0; i < sync_out_pkg::NUM_SYNTH; i++)
        begin
            f = freqs[i];
            vmask[i] = (f != 19'h0_0000) && ((f[0] == 1'b0 && f <= 19'h1_2fc0) ||
                                             (f[2:0] == 3'h0 && f <= 19'h4_bf00));
            apb_xfer(1'b1, sync_out_pkg::CUSTOM_BASE_OFS + 8'(4 * i),
                     {8'(i + 2), 5'h00, f});
            apb_xfer(1'b0, sync_out_pkg::CUSTOM_BASE_OFS + 8'(4 * i), 32'h0000_0000);
            check_word(rd, {8'(i + 2), 5'h00, f}, "custom readback");
        end
        apb_xfer(1'b0, sync_out_pkg::STATUS_OFS, 32'h0000_0000);
        check_word(32'(rd[10:4]), 32'(vmask), "custom valid flags");
        finish_test();
    end

    // Watchdog well beyond the expected run of about ten thousand cycles
    initial
    begin
        #(60000 * 5);
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end
endmodule : sync_out_gen_tb
`default_nettype wire

//--- sync_out_pkg.sv
// Constants, register map and carrier types for the frame and multiframe sync outputs
package sync_out_pkg;

    // Core clock and sync timing, times in ns
    localparam int CORE_CLK_PERIOD_NS = 5;
    localparam int FRAME_PERIOD_NS    = 125000;
    localparam int MFRAME_PERIOD_NS   = 500000;
    localparam int FRAME_CYCLES_DEF   = FRAME_PERIOD_NS / CORE_CLK_PERIOD_NS;
    localparam int FRAMES_PER_MF      = MFRAME_PERIOD_NS / FRAME_PERIOD_NS;
    localparam logic [1:0] MF_LAST_IDX = 2'(FRAMES_PER_MF - 1);
    localparam logic [1:0] MF_HALF_IDX = 2'(FRAMES_PER_MF / 2);

    // Register byte offsets
    localparam logic [7:0] OUT_CFG_OFS     = 8'h00;
    localparam logic [7:0] SYNC_CFG_OFS    = 8'h04;
    localparam logic [7:0] STATUS_OFS      = 8'h08;
    localparam logic [7:0] CUSTOM_BASE_OFS = 8'h10;
    localparam logic [7:0] CUSTOM_LAST_OFS = 8'h28;
    localparam int         NUM_SYNTH       = 7;

    // Field positions
    localparam int FS_EN_BIT      = 0;
    localparam int MF_EN_BIT      = 1;
    localparam int FAST_PULSE_BIT = 0;
    localparam int FAST_INV_BIT   = 1;
    localparam int SLOW_PULSE_BIT = 2;
    localparam int SLOW_INV_BIT   = 3;
    localparam int FS_LVL_BIT     = 0;
    localparam int MF_LVL_BIT     = 1;
    localparam int OC3_LVL_BIT    = 2;
    localparam int VALID_LSB      = 4;
    localparam int FREQ_LSB       = 0;
    localparam int FREQ_W         = 19;
    localparam int DIV_LSB        = 24;
    localparam int DIV_W          = 8;

    // Custom frequency limits in kHz: 77760 and 311040
    localparam logic [FREQ_W-1:0] SLOW_LIMIT_KHZ = 19'h1_2fc0;
    localparam logic [FREQ_W-1:0] FAST_LIMIT_KHZ = 19'h4_bf00;

    // APB request as driven by the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // One synthesizer's custom setting
    typedef struct packed {
        logic [DIV_W-1:0]  div;
        logic [FREQ_W-1:0] freq;
    } custom_t;

    localparam custom_t CUSTOM_RST = '{div: 8'h01, freq: 19'h0_0000};

endpackage : sync_out_pkg

//--- sync_run_monitor.sv
// Downstream framing model: measures high and low run lengths of one sync line
`timescale 1ns/100ps
`default_nettype none

module sync_run_monitor (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        sync_in,
    output var  logic [15:0] high_run,
    output var  logic [15:0] low_run
);
    logic        level_q;
    logic [15:0] run_q;

    // A level change closes the run; old figures stay until the next change
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            level_q  <= 1'b0;
            run_q    <= 16'h0000;
            high_run <= 16'h0000;
            low_run  <= 16'h0000;
        end
        else if (sync_in != level_q)
        begin
            if (level_q)
                high_run <= run_q;
            else
                low_run <= run_q;
            level_q <= sync_in;
            run_q   <= 16'h0001;
        end
        else
            run_q <= run_q + 16'h0001;
    end
endmodule : sync_run_monitor
`default_nettype wire
